// >>> rtl/tfsk_pkg.sv
package tfsk_pkg;
   localparam int ADR_W = 4;
   localparam int DAT_W = 32;
   localparam logic [ADR_W-1:0] OFF_ICTL2 = 4'h0;
   localparam logic [ADR_W-1:0] OFF_FLAGS = 4'h4;
   localparam logic [ADR_W-1:0] OFF_IRQ_STAT = 4'h8;
   localparam logic [ADR_W-1:0] OFF_IRQ_MASK = 4'hC;
   localparam int ICTL2_W = 4;
   localparam int T4_EN_BIT = 3;
   localparam int T5_EN_BIT = 1;
   localparam logic [ICTL2_W-1:0] ICTL2_RST = 4'h0;
   localparam int EVT_W = 2;
   localparam int EVT_T4 = 0;
   localparam int EVT_T5 = 1;
   localparam logic [EVT_W-1:0] FLAG_RST = 2'h0;
   localparam logic [EVT_W-1:0] IRQ_STAT_RST = 2'h0;
   localparam logic [EVT_W-1:0] IRQ_MASK_RST = 2'h0;

   typedef enum logic [1:0] {
      TFSK_OP_OTHER,
      TFSK_OP_SKIP_T4,
      TFSK_OP_SKIP_T5
   } tfsk_op_t;

   typedef struct packed {
      logic valid;
      tfsk_op_t op;
   } tfsk_exec_t;

   typedef struct packed {
      logic [ADR_W-1:0] adr;
      logic we;
      logic [3:0] sel;
      logic [DAT_W-1:0] dat;
   } tfsk_wb_req_t;
endpackage

// >>> rtl/tfsk_skip_unit.sv
`timescale 1ns/1ps
module tfsk_skip_unit (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [tfsk_pkg::ADR_W-1:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [tfsk_pkg::DAT_W-1:0] i_wb_dat,
   output logic [tfsk_pkg::DAT_W-1:0] o_wb_dat,
   output logic o_wb_ack,
   input wire tfsk_pkg::tfsk_exec_t i_exec,
   input wire logic i_timer4_flag_set,
   input wire logic i_timer5_flag_set,
   output logic o_skip_next,
   output logic o_exec_done,
   output logic o_timer4_request_flag,
   output logic o_timer5_request_flag,
   output logic o_irq
);
   tfsk_pkg::tfsk_wb_req_t req;
   logic ack_reg;
   logic access;
   logic [tfsk_pkg::DAT_W-1:0] rdat_reg;
   logic [tfsk_pkg::DAT_W-1:0] rdat_next;
   logic [tfsk_pkg::ICTL2_W-1:0] ictl_reg;
   logic [tfsk_pkg::EVT_W-1:0] flag_reg;
   logic [tfsk_pkg::EVT_W-1:0] stat_reg;
   logic [tfsk_pkg::EVT_W-1:0] stat_clr;
   logic [tfsk_pkg::EVT_W-1:0] mask_reg;
   logic [tfsk_pkg::EVT_W-1:0] hit;
   logic [tfsk_pkg::EVT_W-1:0] flag_set;
   logic [tfsk_pkg::EVT_W-1:0] irq_en;
   logic skip_reg;
   logic done_reg;
   logic irq_reg;

   function automatic logic reg_hit(input logic [tfsk_pkg::ADR_W-1:0] adr,
                                    input logic [tfsk_pkg::ADR_W-1:0] off);
      reg_hit = (adr == off);
   endfunction

   assign req = '{adr: i_wb_adr, we: i_wb_we, sel: i_wb_sel, dat: i_wb_dat};
   // Answer one cycle after the strobe; ack gap stops a held request acting twice
   assign access = i_wb_cyc && i_wb_stb && !ack_reg;
   assign flag_set = {i_timer5_flag_set, i_timer4_flag_set};
   assign irq_en[tfsk_pkg::EVT_T4] = ictl_reg[tfsk_pkg::T4_EN_BIT];
   assign irq_en[tfsk_pkg::EVT_T5] = ictl_reg[tfsk_pkg::T5_EN_BIT];

   genvar gi;
   generate
      for (gi = 0; gi < tfsk_pkg::EVT_W; gi++) begin : g_flag
         localparam tfsk_pkg::tfsk_op_t OP = (gi == tfsk_pkg::EVT_T4) ?
            tfsk_pkg::TFSK_OP_SKIP_T4 : tfsk_pkg::TFSK_OP_SKIP_T5;
         logic flag_bit_reg;
         assign flag_reg[gi] = flag_bit_reg;
         // Enabled interrupt makes the test a no-op: no skip, flag kept, only o_exec_done pulses
         assign hit[gi] = i_exec.valid && (i_exec.op == OP) && !irq_en[gi]
                          && flag_reg[gi];

         // A timer event in the clearing cycle wins, so no request is lost
         always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               flag_bit_reg <= tfsk_pkg::FLAG_RST[gi];
            end else if (flag_set[gi]) begin
               flag_bit_reg <= 1'b1;
            end else if (hit[gi]) begin
               flag_bit_reg <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         skip_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         skip_reg <= |hit;
         done_reg <= i_exec.valid;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= access;
      end
   end

   property p_ack_answer;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("bus request not answered");

   property p_ack_pulse;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_wb_ack |=> !o_wb_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ictl_reg <= tfsk_pkg::ICTL2_RST;
         mask_reg <= tfsk_pkg::IRQ_MASK_RST;
      end else if (access && req.we && req.sel[0]) begin
         if (reg_hit(req.adr, tfsk_pkg::OFF_ICTL2)) begin
            ictl_reg <= req.dat[tfsk_pkg::ICTL2_W-1:0];
         end
         if (reg_hit(req.adr, tfsk_pkg::OFF_IRQ_MASK)) begin
            mask_reg <= req.dat[tfsk_pkg::EVT_W-1:0];
         end
      end
   end

   assign stat_clr = (access && !req.we && reg_hit(req.adr, tfsk_pkg::OFF_IRQ_STAT)) ?
                     {tfsk_pkg::EVT_W{1'b1}} : {tfsk_pkg::EVT_W{1'b0}};

   // Read clears the status, but a skip in that same cycle stays recorded
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stat_reg <= tfsk_pkg::IRQ_STAT_RST;
      end else begin
         stat_reg <= (stat_reg & ~stat_clr) | hit;
      end
   end

   property p_stat_clear;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (access && !i_wb_we && i_wb_adr == tfsk_pkg::OFF_IRQ_STAT && !i_exec.valid)
      |=> stat_reg == '0;
   endproperty
   a_stat_clear: assert property (p_stat_clear) else $error("status not cleared by read");

   // Interrupt follows status one cycle late, to keep the output on a flop
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(stat_reg & mask_reg);
      end
   end

   property p_irq_level;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      1'b1 |=> o_irq == |($past(stat_reg) & $past(mask_reg));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq does not follow status");

   always_comb begin
      rdat_next = '0;
      if (reg_hit(req.adr, tfsk_pkg::OFF_ICTL2)) begin
         rdat_next[tfsk_pkg::ICTL2_W-1:0] = ictl_reg;
      end else if (reg_hit(req.adr, tfsk_pkg::OFF_FLAGS)) begin
         rdat_next[tfsk_pkg::EVT_W-1:0] = flag_reg;
      end else if (reg_hit(req.adr, tfsk_pkg::OFF_IRQ_STAT)) begin
         rdat_next[tfsk_pkg::EVT_W-1:0] = stat_reg;
      end else if (reg_hit(req.adr, tfsk_pkg::OFF_IRQ_MASK)) begin
         rdat_next[tfsk_pkg::EVT_W-1:0] = mask_reg;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdat_reg <= '0;
      end else if (access && !req.we) begin
         rdat_reg <= rdat_next;
      end
   end

   assign o_wb_dat = rdat_reg;
   assign o_wb_ack = ack_reg;
   assign o_skip_next = skip_reg;
   assign o_exec_done = done_reg;
   assign o_timer4_request_flag = flag_reg[tfsk_pkg::EVT_T4];
   assign o_timer5_request_flag = flag_reg[tfsk_pkg::EVT_T5];
   assign o_irq = irq_reg;

   sequence s_t4_test;
      i_exec.valid && i_exec.op == tfsk_pkg::TFSK_OP_SKIP_T4 && !ictl_reg[3];
   endsequence

   sequence s_t5_test;
      i_exec.valid && i_exec.op == tfsk_pkg::TFSK_OP_SKIP_T5 && !ictl_reg[1];
   endsequence

   property p_t4_skip;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (s_t4_test and o_timer4_request_flag) |=> o_skip_next;
   endproperty
   a_t4_skip: assert property (p_t4_skip) else $error("t4 skip missing");

   property p_t4_clear;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (s_t4_test and o_timer4_request_flag && !i_timer4_flag_set)
      |=> !o_timer4_request_flag;
   endproperty
   a_t4_clear: assert property (p_t4_clear) else $error("t4 flag not cleared");

   property p_t4_nop;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_exec.valid && i_exec.op == tfsk_pkg::TFSK_OP_SKIP_T4 && ictl_reg[3]
       && !i_timer4_flag_set)
      |=> !o_skip_next && o_timer4_request_flag == $past(o_timer4_request_flag);
   endproperty
   a_t4_nop: assert property (p_t4_nop) else $error("t4 nop acted");

   property p_t4_en_bit;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (access && i_wb_we && i_wb_sel[0] && i_wb_adr == 4'h0)
      |=> irq_en[0] == $past(i_wb_dat[3]);
   endproperty
   a_t4_en_bit: assert property (p_t4_en_bit) else $error("t4 enable bit wrong");

   property p_t5_skip;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (s_t5_test and o_timer5_request_flag) |=> o_skip_next;
   endproperty
   a_t5_skip: assert property (p_t5_skip) else $error("t5 skip missing");

   property p_t5_clear;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (s_t5_test and o_timer5_request_flag && !i_timer5_flag_set)
      |=> !o_timer5_request_flag;
   endproperty
   a_t5_clear: assert property (p_t5_clear) else $error("t5 flag not cleared");

   property p_t5_nop;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_exec.valid && i_exec.op == tfsk_pkg::TFSK_OP_SKIP_T5 && ictl_reg[1]
       && !i_timer5_flag_set)
      |=> !o_skip_next && o_timer5_request_flag == $past(o_timer5_request_flag);
   endproperty
   a_t5_nop: assert property (p_t5_nop) else $error("t5 nop acted");

   property p_t5_en_bit;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (access && i_wb_we && i_wb_sel[0] && i_wb_adr == 4'h0)
      |=> irq_en[1] == $past(i_wb_dat[1]);
   endproperty
   a_t5_en_bit: assert property (p_t5_en_bit) else $error("t5 enable bit wrong");

   property p_one_cycle;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (!i_exec.valid) |=> !o_skip_next && !o_exec_done;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("stray skip or done");

   property p_done;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_exec.valid |=> o_exec_done;
   endproperty
   a_done: assert property (p_done) else $error("exec not done in one cycle");

   property p_t4_status;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (s_t4_test and o_timer4_request_flag) |=> stat_reg[tfsk_pkg::EVT_T4];
   endproperty
   a_t4_status: assert property (p_t4_status) else $error("t4 skip not recorded");

   property p_t5_status;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (s_t5_test and o_timer5_request_flag) |=> stat_reg[tfsk_pkg::EVT_T5];
   endproperty
   a_t5_status: assert property (p_t5_status) else $error("t5 skip not recorded");

   property p_t4_set_wins;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_timer4_flag_set |=> o_timer4_request_flag;
   endproperty
   a_t4_set_wins: assert property (p_t4_set_wins) else $error("t4 set lost");

   property p_t5_set_wins;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_timer5_flag_set |=> o_timer5_request_flag;
   endproperty
   a_t5_set_wins: assert property (p_t5_set_wins) else $error("t5 set lost");

   property p_t4_hold;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (!i_timer4_flag_set && !(i_exec.valid && i_exec.op == tfsk_pkg::TFSK_OP_SKIP_T4))
      |=> $stable(o_timer4_request_flag);
   endproperty
   a_t4_hold: assert property (p_t4_hold) else $error("t4 flag moved on its own");

   property p_t5_hold;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (!i_timer5_flag_set && !(i_exec.valid && i_exec.op == tfsk_pkg::TFSK_OP_SKIP_T5))
      |=> $stable(o_timer5_request_flag);
   endproperty
   a_t5_hold: assert property (p_t5_hold) else $error("t5 flag moved on its own");

   property p_skip_done;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_skip_next |-> o_exec_done;
   endproperty
   a_skip_done: assert property (p_skip_done) else $error("skip without done");
endmodule // tfsk_skip_unit

// >>> test/tfsk_skip_unit_tb.sv
`timescale 1ns/1ps
module tfsk_skip_unit_tb;
   logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic fire4 = 1'b0, fire5 = 1'b0, set4, set5, skip, done, f4o, f5o, irq, ack;
   logic [3:0] adr = 4'h0, sel = 4'hF;
   logic [31:0] wdat = 32'h0, rdat, q;
   tfsk_pkg::tfsk_exec_t exec = '0;
   tfsk_pkg::tfsk_op_t op;
   logic [2:0] expq[$];
   logic [7:0] r = 8'h0E;
   logic [3:0] ctl;
   logic [1:0] msk, st;
   logic f4, f5, en, fl, sk;
   int fails = 0, checks = 0;
   always #50 clk = ~clk;
   tfsk_timer_model i_tfsk_timer_model (.i_core_clk(clk), .i_rst_n(rst_n), .i_fire4(fire4),
      .i_fire5(fire5), .o_set4(set4), .o_set5(set5));
   tfsk_skip_unit i_tfsk_skip_unit (.i_core_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_exec(exec), .i_timer4_flag_set(set4),
      .i_timer5_flag_set(set5), .o_skip_next(skip), .o_exec_done(done),
      .o_timer4_request_flag(f4o), .o_timer5_request_flag(f5o), .o_irq(irq));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic end_of_test();
      if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: word got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_exec(input logic [2:0] got, input logic [2:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: skip/flags got %b expected %b", $time, got, exp);
      end
   endtask
   // Held until ack is sampled high; released only after that edge
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   always @(posedge clk) begin
      if (rst_n && done === 1'b1) begin
         if (expq.size() == 0) cmp_exec({skip, f4o, f5o}, 3'bxxx);
         else cmp_exec({skip, f4o, f5o}, expq.pop_front());
      end else if (rst_n && skip === 1'b1) cmp_word(32'h1, 32'h0);
   end
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      end_of_test();
   end
   initial begin
      f4 = 1'b0; f5 = 1'b0; st = 2'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (int b = 0; b < 4; b++) begin
         ctl = {b[1], 1'b0, b[0], 1'b0};
         msk = b[1:0];
         wb(1'b1, tfsk_pkg::OFF_ICTL2, {28'h0, ctl});
         wb(1'b1, tfsk_pkg::OFF_IRQ_MASK, {30'h0, msk});
         wb(1'b0, tfsk_pkg::OFF_ICTL2, 32'h0);
         cmp_word(q, {28'h0, ctl});
         sel <= 4'hE;
         wb(1'b1, tfsk_pkg::OFF_ICTL2, {28'h0, ~ctl});
         sel <= 4'hF;
         wb(1'b0, tfsk_pkg::OFF_ICTL2, 32'h0);
         cmp_word(q, {28'h0, ctl});
         for (int i = 0; i < 20; i++) begin
            r = lfsr(r);
            fire4 <= r[0];
            fire5 <= r[1];
            @(posedge clk);
            fire4 <= 1'b0;
            fire5 <= 1'b0;
            f4 |= r[0];
            f5 |= r[1];
            repeat (3) @(posedge clk);
            op = (r[3:2] == 2'h2) ? tfsk_pkg::TFSK_OP_SKIP_T5 :
                 (r[3:2] == 2'h0) ? tfsk_pkg::TFSK_OP_OTHER : tfsk_pkg::TFSK_OP_SKIP_T4;
            // Second copy back to back: the first skip must already have cleared the flag
            for (int k = 0; k <= int'(r[4]); k++) begin
               en = (op == tfsk_pkg::TFSK_OP_SKIP_T4) ? ctl[3] : ctl[1];
               fl = (op == tfsk_pkg::TFSK_OP_SKIP_T4) ? f4 : f5;
               sk = (op != tfsk_pkg::TFSK_OP_OTHER) && !en && fl;
               if (sk && op == tfsk_pkg::TFSK_OP_SKIP_T4) begin
                  f4 = 1'b0;
                  st[0] = 1'b1;
               end
               if (sk && op == tfsk_pkg::TFSK_OP_SKIP_T5) begin
                  f5 = 1'b0;
                  st[1] = 1'b1;
               end
               expq.push_back({sk, f4, f5});
               exec <= '{valid: 1'b1, op: op};
               @(posedge clk);
            end
            exec <= '0;
            repeat (2) @(posedge clk);
         end
         cmp_word({31'h0, irq}, {31'h0, |(st & msk)});
         wb(1'b0, tfsk_pkg::OFF_IRQ_STAT, 32'h0);
         cmp_word(q, {30'h0, st});
         st = 2'h0;
         wb(1'b1, tfsk_pkg::OFF_FLAGS, 32'hFFFF_FFFF);
         wb(1'b0, tfsk_pkg::OFF_FLAGS, 32'h0);
         cmp_word(q, {30'h0, f5, f4});
         wb(1'b0, 4'h2, 32'h0);
         cmp_word(q, 32'h0);
      end
      repeat (3) @(posedge clk);
      cmp_word(expq.size(), 32'h0);
      // Mid-run reset must drop the flags and the control register
      rst_n <= 1'b0;
      @(posedge clk);
      cmp_exec({skip, f4o, f5o}, 3'b000);
      rst_n <= 1'b1;
      wb(1'b0, tfsk_pkg::OFF_ICTL2, 32'h0);
      cmp_word(q, 32'h0);
      end_of_test();
   end
endmodule // tfsk_skip_unit_tb

// >>> test/tfsk_timer_model.sv
`timescale 1ns/1ps
module tfsk_timer_model (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_fire4,
   input wire logic i_fire5,
   output logic o_set4,
   output logic o_set5
);
   // Overflow reaches the flag logic one clock late, as a single-cycle set pulse
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_set4 <= 1'b0;
         o_set5 <= 1'b0;
      end else begin
         o_set4 <= i_fire4;
         o_set5 <= i_fire5;
      end
   end
endmodule // tfsk_timer_model
